/* File: hdl/tisp_pkg.sv */
// Shared constants for the interrupt status and pin output block.
// Assumes a 100 MHz system clock and an APB register port with 12-bit byte addresses.
package tisp_pkg;

	// =====================================================================
	// Register byte addresses
	localparam logic [11:0] ADDR_PIN_CFG = 12'h054;
	localparam logic [11:0] ADDR_SRC_STS = 12'h058;
	localparam logic [11:0] ADDR_SRC_EN  = 12'h05c;

	// =====================================================================
	// Pin configuration field positions
	localparam int unsigned CFG_HOLDOFF_LSB = 24;
	localparam int unsigned CFG_HOLDOFF_W   = 8;
	localparam int unsigned CFG_HOLDOFF_CLR = 14;
	localparam int unsigned CFG_HOLDOFF_STS = 13;
	localparam int unsigned CFG_GLOBAL_IRQ  = 12;
	localparam int unsigned CFG_OUT_EN      = 8;
	localparam int unsigned CFG_POL         = 4;
	localparam int unsigned CFG_CLK_SEL     = 1;
	localparam int unsigned CFG_BUF_TYPE    = 0;

	// =====================================================================
	// Status and enable bit positions (both registers share the layout)
	localparam int unsigned STS_SW     = 31;
	localparam int unsigned STS_READY  = 30;
	localparam int unsigned STS_TSU    = 29;
	localparam int unsigned STS_FABRIC = 28;
	localparam int unsigned STS_PHY_B  = 27;
	localparam int unsigned STS_PHY_A  = 26;
	localparam int unsigned STS_GPT    = 19;
	localparam int unsigned STS_PME    = 17;
	localparam int unsigned STS_GPIO   = 12;

	localparam logic [31:0] STS_IMPL_MASK   = 32'hfc0a_1000;
	localparam logic [31:0] STS_W1C_MASK    = 32'hc00a_0000;
	localparam logic [31:0] STS_MIRROR_MASK = 32'h3c00_1000;

	// =====================================================================
	// Reset values
	localparam logic [31:0] STS_RESET     = 32'h0000_0000;
	localparam logic [31:0] EN_RESET      = 32'h0000_0000;
	localparam logic [7:0]  HOLDOFF_RESET = 8'h00;
	localparam logic        POL_RESET     = 1'b0;
	localparam logic        BUF_RESET     = 1'b0;
	localparam logic        CLK_SEL_RESET = 1'b0;
	localparam logic        OUT_EN_RESET  = 1'b0;

	// =====================================================================
	// Timing
	localparam int unsigned CLK_PERIOD_NS    = 10;
	localparam int unsigned HOLDOFF_UNIT_NS  = 10000;
	localparam int unsigned HOLDOFF_UNIT_CYC = HOLDOFF_UNIT_NS / CLK_PERIOD_NS;

	typedef enum logic {HO_IDLE, HO_COUNT} tisp_holdoff_state_t;

	// Byte strobes widened to a bit mask
	function automatic logic [31:0] tisp_strobe_mask(input logic [3:0] strb);
		tisp_strobe_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
	endfunction

endpackage

/* File: hdl/tisp_holdoff.sv */
// Hold-off interval timer: keeps the pin quiet for a programmed number of units after release.
// Assumes reset_i already combines full and digital reset, synchronous to clk_i.
`timescale 1ns/10ps
`default_nettype none
module tisp_holdoff #(
	parameter int unsigned UNIT_CYC = tisp_pkg::HOLDOFF_UNIT_CYC
) (
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	input  wire logic       pin_req_i,
	input  wire logic [7:0] interval_i,
	input  wire logic       restart_i,
	output logic            active_o
);
	import tisp_pkg::*;

	tisp_holdoff_state_t state_q;
	logic [7:0]          units_q;
	logic [15:0]         pre_q;
	logic                req_prev_q;
	logic                release_ev;

	assign release_ev = req_prev_q & ~pin_req_i;
	assign active_o   = (state_q == HO_COUNT);

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			req_prev_q <= 1'b0;
		end else begin
			req_prev_q <= pin_req_i;
		end
	end

	// =====================================================================
	// Interval counter
	always_ff @(posedge clk_i) begin
		if (reset_i || interval_i == 8'h00) begin
			// Zero interval cancels any running hold-off at once
			state_q <= HO_IDLE;
			units_q <= 8'h00;
			pre_q   <= 16'h0000;
		end else if (restart_i || release_ev) begin
			state_q <= HO_COUNT;
			units_q <= interval_i;
			pre_q   <= 16'h0000;
		end else begin
			unique case (state_q)
				HO_IDLE: begin
					pre_q <= 16'h0000;
				end
				HO_COUNT: begin
					if (pre_q == 16'(UNIT_CYC - 1)) begin
						pre_q <= 16'h0000;
						if (units_q == 8'h01) begin
							state_q <= HO_IDLE;
						end
						units_q <= units_q - 8'h01;
					end else begin
						pre_q <= pre_q + 16'h0001;
					end
				end
			endcase
		end
	end

	hold_start_a: assert property (@(posedge clk_i) disable iff (reset_i)
		release_ev && interval_i != 8'h00 |=> active_o && units_q == $past(interval_i))
		else $error("hold-off did not start after pin release");

	hold_zero_a: assert property (@(posedge clk_i) disable iff (reset_i)
		interval_i == 8'h00 |=> !active_o)
		else $error("hold-off active with zero interval");

endmodule
`default_nettype wire

/* File: hdl/tisp_pin_drv.sv */
// Interrupt pin output stage: polarity, buffer type and debug clock routing.
// Assumes the pad merges out and enable; xtal_i is sampled on clk_i like any input.
`timescale 1ns/10ps
`default_nettype none
module tisp_pin_drv (
	input  wire logic clk_i,
	input  wire logic reset_i,
	input  wire logic assert_i,
	input  wire logic pol_i,
	input  wire logic buf_type_i,
	input  wire logic clk_sel_i,
	input  wire logic xtal_i,
	output logic      pin_o,
	output logic      pin_oe_o
);
	logic level;

	// Debug clock replaces the interrupt function; registering it limits its fidelity
	assign level = clk_sel_i ? xtal_i : (assert_i ? pol_i : ~pol_i);

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			pin_o    <= 1'b0;
			pin_oe_o <= 1'b0;
		end else if (buf_type_i) begin
			pin_o    <= level;
			pin_oe_o <= 1'b1;
		end else begin
			// Open-drain only ever pulls low, polarity has no say
			pin_o    <= 1'b0;
			pin_oe_o <= clk_sel_i ? ~xtal_i : assert_i;
		end
	end

	od_pull_low_a: assert property (@(posedge clk_i) disable iff (reset_i)
		!buf_type_i && !clk_sel_i |=> !pin_o && pin_oe_o == $past(assert_i))
		else $error("open-drain pin not pulling low on assertion");

	pp_polarity_a: assert property (@(posedge clk_i) disable iff (reset_i)
		buf_type_i && !clk_sel_i |=> pin_oe_o && pin_o == ($past(assert_i) ~^ $past(pol_i)))
		else $error("push-pull level does not follow polarity");

	clk_route_a: assert property (@(posedge clk_i) disable iff (reset_i)
		buf_type_i && clk_sel_i |=> pin_o == $past(xtal_i))
		else $error("debug clock not routed to pin");

endmodule
`default_nettype wire

/* File: hdl/tisp_top.sv */
// Interrupt source status, enables and pin configuration behind an APB slave.
// Assumes all source inputs are synchronous to clk_i; soft_reset_i is the digital reset.
//
// Our own choice: register access over APB.
`timescale 1ns/10ps
`default_nettype none
module tisp_top #(
	parameter int unsigned HOLDOFF_UNIT_CYC = tisp_pkg::HOLDOFF_UNIT_CYC
) (
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	input  wire logic        soft_reset_i,
	// APB slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	input  wire logic [3:0]  pstrb_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// Interrupt sources
	input  wire logic        device_ready_i,
	input  wire logic        timestamp_unit_event_i,
	input  wire logic        fabric_irq_i,
	input  wire logic        phy_b_irq_i,
	input  wire logic        phy_a_irq_i,
	input  wire logic        gp_timer_wrap_i,
	input  wire logic        power_event_i,
	input  wire logic        power_flags_pending_i,
	input  wire logic        general_io_irq_i,
	// Pin
	input  wire logic        xtal_clk_i,
	output logic             irq_pin_o,
	output logic             irq_pin_oe_o
);
	import tisp_pkg::*;

	// =====================================================================
	// Declarations
	logic        dig_rst;
	logic        setup_ph;
	logic        fire;
	logic        wr_fire;
	logic        hit_cfg;
	logic        hit_sts;
	logic        hit_en;
	logic [31:0] wmask;
	logic [31:0] wbits;

	logic [31:0] sts_q;
	logic [31:0] sts_d;
	logic [31:0] en_q;
	logic        ready_prev_q;
	logic [7:0]  holdoff_q;
	logic        out_en_q;
	logic        pol_q;
	logic        clk_sel_q;
	logic        buf_type_q;

	logic [31:0] set_vec;
	logic [31:0] clr_vec;
	logic [31:0] mirror_vec;
	logic [31:0] pending;
	logic        any_enabled;
	logic        nonpme_req;
	logic        pme_req;
	logic        pin_req;
	logic        pin_assert;
	logic        holdoff_active;
	logic        holdoff_restart;
	logic [31:0] cfg_view;
	logic [31:0] rd_val;

	assign dig_rst = reset_i | soft_reset_i;

	// =====================================================================
	// APB slave: one setup, one access cycle, no extra waits
	assign setup_ph = psel_i & ~penable_i;
	assign fire     = psel_i & penable_i & pready_o;
	assign wr_fire  = fire & pwrite_i;
	assign hit_cfg  = (paddr_i == ADDR_PIN_CFG);
	assign hit_sts  = (paddr_i == ADDR_SRC_STS);
	assign hit_en   = (paddr_i == ADDR_SRC_EN);
	assign wmask    = tisp_strobe_mask(pstrb_i);
	assign wbits    = pwdata_i & wmask;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
		end else begin
			pready_o  <= setup_ph;
			pslverr_o <= setup_ph & ~(hit_cfg | hit_sts | hit_en);
		end
	end

	// Read data is captured in the setup cycle so prdata_o is a flop
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			prdata_o <= 32'h0000_0000;
		end else if (setup_ph && !pwrite_i) begin
			prdata_o <= rd_val;
		end else if (fire) begin
			prdata_o <= 32'h0000_0000;
		end
	end

	always_comb begin
		cfg_view = 32'h0000_0000;
		cfg_view[CFG_HOLDOFF_LSB +: CFG_HOLDOFF_W] = holdoff_q;
		cfg_view[CFG_HOLDOFF_STS] = holdoff_active;
		cfg_view[CFG_GLOBAL_IRQ]  = any_enabled;
		cfg_view[CFG_OUT_EN]      = out_en_q;
		cfg_view[CFG_POL]         = pol_q;
		cfg_view[CFG_CLK_SEL]     = clk_sel_q;
		cfg_view[CFG_BUF_TYPE]    = buf_type_q;
		if (hit_cfg) begin
			rd_val = cfg_view;
		end else if (hit_sts) begin
			rd_val = sts_q & STS_IMPL_MASK;
		end else if (hit_en) begin
			rd_val = en_q & STS_IMPL_MASK;
		end else begin
			rd_val = 32'h0000_0000;
		end
	end

	// =====================================================================
	// Pin configuration
	always_ff @(posedge clk_i) begin
		if (dig_rst) begin
			holdoff_q  <= HOLDOFF_RESET;
			out_en_q   <= OUT_EN_RESET;
			clk_sel_q  <= CLK_SEL_RESET;
			buf_type_q <= BUF_RESET;
		end else if (wr_fire && hit_cfg) begin
			if (pstrb_i[3]) begin
				holdoff_q <= pwdata_i[CFG_HOLDOFF_LSB +: CFG_HOLDOFF_W];
			end
			if (pstrb_i[1]) begin
				out_en_q <= pwdata_i[CFG_OUT_EN];
			end
			if (pstrb_i[0]) begin
				clk_sel_q  <= pwdata_i[CFG_CLK_SEL];
				buf_type_q <= pwdata_i[CFG_BUF_TYPE];
			end
		end
	end

	// Polarity sits apart: only the full reset may restore it
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			pol_q <= POL_RESET;
		end else if (wr_fire && hit_cfg && pstrb_i[0]) begin
			pol_q <= pwdata_i[CFG_POL];
		end
	end

	// Self-clearing: the counter restart is a pulse, the bit reads zero
	assign holdoff_restart = wr_fire & hit_cfg & wbits[CFG_HOLDOFF_CLR];

	// =====================================================================
	// Enable register
	always_ff @(posedge clk_i) begin
		if (dig_rst) begin
			en_q <= EN_RESET;
		end else if (wr_fire && hit_en) begin
			en_q <= ((en_q & ~wmask) | wbits) & STS_IMPL_MASK;
		end
	end

	// =====================================================================
	// Status register
	always_ff @(posedge clk_i) begin
		if (dig_rst) begin
			ready_prev_q <= 1'b0;
		end else begin
			ready_prev_q <= device_ready_i;
		end
	end

	always_comb begin
		set_vec = 32'h0000_0000;
		// Software event fires when the trigger enable goes from 0 to 1
		set_vec[STS_SW]    = wr_fire & hit_en & wbits[STS_SW] & ~en_q[STS_SW];
		set_vec[STS_READY] = device_ready_i & ~ready_prev_q;
		set_vec[STS_GPT]   = gp_timer_wrap_i;
		set_vec[STS_PME]   = power_event_i;

		mirror_vec = 32'h0000_0000;
		mirror_vec[STS_TSU]    = timestamp_unit_event_i;
		mirror_vec[STS_FABRIC] = fabric_irq_i;
		mirror_vec[STS_PHY_B]  = phy_b_irq_i;
		mirror_vec[STS_PHY_A]  = phy_a_irq_i;
		mirror_vec[STS_GPIO]   = general_io_irq_i;

		clr_vec = 32'h0000_0000;
		if (wr_fire && hit_sts) begin
			clr_vec = wbits & STS_W1C_MASK;
		end
		// Power flag refuses its clear while the power block still has flags up
		clr_vec[STS_PME] = clr_vec[STS_PME] & ~power_flags_pending_i;

		sts_d = (((sts_q & ~clr_vec) | set_vec) & STS_W1C_MASK) | mirror_vec;
	end

	always_ff @(posedge clk_i) begin
		if (dig_rst) begin
			sts_q <= STS_RESET;
		end else begin
			sts_q <= sts_d;
		end
	end

	// =====================================================================
	// Combining and pin assertion
	assign pending     = sts_q & en_q & STS_IMPL_MASK;
	assign any_enabled = |pending;
	// Power bit kept apart so it can skip the hold-off
	assign pme_req     = pending[STS_PME];
	assign nonpme_req  = |(pending & ~(32'h1 << STS_PME));
	// The hold-off watches the gated request so its release starts the interval
	assign pin_req     = out_en_q & nonpme_req & ~holdoff_active;
	assign pin_assert  = pin_req | (out_en_q & pme_req);

	// Restart and release both reload the interval count
	tisp_holdoff #(
		.UNIT_CYC (HOLDOFF_UNIT_CYC)
	) u_holdoff (
		.clk_i      (clk_i),
		.reset_i    (dig_rst),
		.pin_req_i  (pin_req),
		.interval_i (holdoff_q),
		.restart_i  (holdoff_restart),
		.active_o   (holdoff_active)
	);

	tisp_pin_drv u_pin (
		.clk_i      (clk_i),
		.reset_i    (dig_rst),
		.assert_i   (pin_assert),
		.pol_i      (pol_q),
		.buf_type_i (buf_type_q),
		.clk_sel_i  (clk_sel_q),
		.xtal_i     (xtal_clk_i),
		.pin_o      (irq_pin_o),
		.pin_oe_o   (irq_pin_oe_o)
	);

	// =====================================================================
	// Checks
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (reset_i);
	// Full reset silences every check; digital reset is excluded term by term

	// Transfer phases; other terms join them through sequence and
	sequence apb_setup_s;
		psel_i && !penable_i;
	endsequence

	sequence apb_access_s;
		psel_i && penable_i && pready_o;
	endsequence

	raw_mirror_a: assert property (
		!soft_reset_i |=> sts_q[STS_TSU] == $past(timestamp_unit_event_i)
			&& sts_q[STS_PHY_A] == $past(phy_a_irq_i))
		else $error("summary bit does not mirror its source");

	set_wins_a: assert property (
		gp_timer_wrap_i && !soft_reset_i |=> sts_q[STS_GPT])
		else $error("timer event lost against a clear");

	w1c_clear_a: assert property (
		apb_setup_s ##1 (apb_access_s and (pwrite_i && hit_sts && wbits[STS_GPT]
			&& !gp_timer_wrap_i && !soft_reset_i)) |=> !sts_q[STS_GPT])
		else $error("write of one did not clear timer bit");

	pme_hold_a: assert property (
		(apb_access_s and (pwrite_i && hit_sts && sts_q[STS_PME] && power_flags_pending_i
			&& !soft_reset_i)) |=> sts_q[STS_PME])
		else $error("power bit cleared while flags still pending");

	sw_trigger_a: assert property (
		(apb_access_s and (pwrite_i && hit_en && wbits[STS_SW] && !en_q[STS_SW]
			&& !soft_reset_i)) |=> sts_q[STS_SW] && en_q[STS_SW])
		else $error("software trigger did not raise its flag");

	ready_set_a: assert property (
		device_ready_i && !ready_prev_q && !soft_reset_i |=> sts_q[STS_READY])
		else $error("device ready edge did not set its flag");

	pol_keep_a: assert property (
		soft_reset_i |=> pol_q == $past(pol_q))
		else $error("polarity lost on digital reset");

	global_read_a: assert property (
		(apb_setup_s and (!pwrite_i && hit_cfg))
			|=> prdata_o[CFG_GLOBAL_IRQ] == $past(any_enabled))
		else $error("global bit read back wrong");

	out_off_a: assert property (
		(!out_en_q && !clk_sel_q && !buf_type_q && !soft_reset_i) [*2] |-> !irq_pin_oe_o)
		else $error("pin asserted with output disabled");

	pme_bypass_a: assert property (
		pme_req && out_en_q && holdoff_active && !clk_sel_q && !soft_reset_i
			|=> irq_pin_oe_o && irq_pin_o == ($past(buf_type_q) && $past(pol_q)))
		else $error("power interrupt held off");

	unmapped_a: assert property (
		(apb_setup_s and !(hit_cfg || hit_sts || hit_en)) |=> pslverr_o && pready_o)
		else $error("unmapped address not flagged");

endmodule
`default_nettype wire

/* File: sim/tisp_host_model.sv */
// Host interrupt input model: the board line shared with the device pin.
// Assumes the device splits the pin into a value and a drive enable.
`timescale 1ns/10ps
`default_nettype none
module tisp_host_model (
	input  wire logic pin_i,
	input  wire logic pin_oe_i,
	output logic      line_o
);
	// =====================================================================
	// Line resolution
	// Board pull-up: a released line reads high, never the last driven value
	assign line_o = pin_oe_i ? pin_i : 1'b1;
endmodule
`default_nettype wire

/* File: sim/tisp_top_test.sv */
// Self-checking bench for the interrupt status and pin output block.
// Assumes the host model supplies the pull-up of the interrupt line.
`timescale 1ns/10ps
`default_nettype none
module tisp_top_test;
	import tisp_pkg::*;
	// Short hold-off unit keeps the interval tests quick
	localparam int unsigned UNIT = 4;
	logic        clk_i, reset_i, soft_reset_i;
	logic        psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [4:0]  mir;
	logic        dev_rdy, gpt, pwr_ev, pwr_pend, xtal, pin, pin_oe, line;
	logic [3:0]  strb;
	int          fails, n_checks;

	tisp_top #(.HOLDOFF_UNIT_CYC(UNIT)) u_tisp_top (
		.clk_i(clk_i), .reset_i(reset_i), .soft_reset_i(soft_reset_i),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
		.pwdata_i(pwdata), .pstrb_i(strb), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .device_ready_i(dev_rdy), .timestamp_unit_event_i(mir[4]),
		.fabric_irq_i(mir[3]), .phy_b_irq_i(mir[2]), .phy_a_irq_i(mir[1]),
		.gp_timer_wrap_i(gpt), .power_event_i(pwr_ev), .power_flags_pending_i(pwr_pend),
		.general_io_irq_i(mir[0]), .xtal_clk_i(xtal), .irq_pin_o(pin), .irq_pin_oe_o(pin_oe)
	);
	tisp_host_model u_tisp_host_model (.pin_i(pin), .pin_oe_i(pin_oe), .line_o(line));

	// =====================================================================
	// Checking and closing
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic timeout(input string nm);
		fails++;
		$display("[ERR] %s expected answer seen timeout", nm);
		tally_and_finish();
	endtask

	// =====================================================================
	// APB master and pin wait
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int k;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk_i);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1) timeout("apb");
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic reg_rd(input logic [11:0] a, input logic [31:0] exp, input string nm);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		chk(nm, r, exp);
	endtask
	task automatic wait_line(input logic exp, input string nm);
		int k;
		for (k = 0; k < 50 && line !== exp; k++) begin
			@(posedge clk_i);
		end
		if (line !== exp) timeout(nm);
		chk(nm, {31'h0, line}, {31'h0, exp});
	endtask

	// =====================================================================
	// Scenarios
	task automatic t_reset();
		logic [31:0] r;
		logic        e;
		reg_rd(ADDR_PIN_CFG, 32'h0, "cfg reset");
		reg_rd(ADDR_SRC_STS, 32'h0, "sts reset");
		reg_rd(ADDR_SRC_EN, 32'h0, "en reset");
		reg_wr(ADDR_PIN_CFG, 32'h00ff_beec);
		reg_rd(ADDR_PIN_CFG, 32'h0, "cfg reserved");
		reg_wr(ADDR_SRC_EN, 32'h03f5_efff);
		reg_rd(ADDR_SRC_EN, 32'h0, "en reserved");
		// Only the byte holding the output enable is written
		strb <= 4'h2;
		reg_wr(ADDR_PIN_CFG, 32'h0000_0111);
		strb <= 4'hf;
		reg_rd(ADDR_PIN_CFG, 32'h0000_0100, "byte strobe");
		reg_wr(ADDR_PIN_CFG, 32'h0);
		apb(1'b0, 12'h060, 32'h0, r, e);
		chk("unmapped error", {31'h0, e}, 32'h1);
		chk("unmapped data", r, 32'h0);
		$display("test reset done");
	endtask
	task automatic t_mirror();
		int pos [5] = '{29, 28, 27, 26, 12};
		for (int i = 0; i < 5; i++) begin
			mir <= 5'h10 >> i;
			repeat (2) @(posedge clk_i);
			reg_rd(ADDR_SRC_STS, 32'h1 << pos[i], "mirror set");
			reg_wr(ADDR_SRC_STS, STS_MIRROR_MASK);
			reg_rd(ADDR_SRC_STS, 32'h1 << pos[i], "mirror kept");
		end
		mir <= 5'h00;
		repeat (2) @(posedge clk_i);
		reg_rd(ADDR_SRC_STS, 32'h0, "mirror clear");
		$display("test mirror done");
	endtask
	task automatic t_w1c();
		dev_rdy <= 1'b1;
		repeat (2) @(posedge clk_i);
		reg_rd(ADDR_SRC_STS, 32'h4000_0000, "ready set");
		reg_wr(ADDR_SRC_STS, 32'h0);
		reg_rd(ADDR_SRC_STS, 32'h4000_0000, "zero write kept");
		gpt <= 1'b1;
		@(posedge clk_i);
		gpt <= 1'b0;
		@(posedge clk_i);
		reg_rd(ADDR_SRC_STS, 32'h4008_0000, "timer wrap");
		reg_wr(ADDR_SRC_STS, 32'h4000_0000);
		reg_rd(ADDR_SRC_STS, 32'h0008_0000, "ready clear");
		reg_wr(ADDR_SRC_STS, 32'h0008_0000);
		reg_rd(ADDR_SRC_STS, 32'h0, "timer clear");
		reg_wr(ADDR_SRC_EN, 32'h8000_0000);
		reg_rd(ADDR_SRC_STS, 32'h8000_0000, "sw flag set");
		reg_wr(ADDR_SRC_STS, 32'h8000_0000);
		reg_rd(ADDR_SRC_STS, 32'h0, "sw flag clear");
		reg_wr(ADDR_SRC_EN, 32'h0);
		pwr_pend <= 1'b1;
		pwr_ev <= 1'b1;
		@(posedge clk_i);
		pwr_ev <= 1'b0;
		@(posedge clk_i);
		reg_rd(ADDR_SRC_STS, 32'h0002_0000, "power set");
		reg_wr(ADDR_SRC_STS, 32'h0002_0000);
		reg_rd(ADDR_SRC_STS, 32'h0002_0000, "power blocked");
		pwr_pend <= 1'b0;
		@(posedge clk_i);
		reg_wr(ADDR_SRC_STS, 32'h0002_0000);
		reg_rd(ADDR_SRC_STS, 32'h0, "power clear");
		$display("test w1c done");
	endtask
	task automatic t_pin();
		reg_wr(ADDR_SRC_EN, 32'h0402_0000);
		reg_wr(ADDR_PIN_CFG, 32'h0000_0101);
		mir <= 5'h02;
		wait_line(1'b0, "push-pull low");
		reg_rd(ADDR_PIN_CFG, 32'h0000_1101, "global bit");
		reg_wr(ADDR_PIN_CFG, 32'h0000_0111);
		wait_line(1'b1, "push-pull high");
		reg_wr(ADDR_PIN_CFG, 32'h0000_0110);
		wait_line(1'b0, "open-drain low");
		reg_wr(ADDR_PIN_CFG, 32'h0000_0010);
		wait_line(1'b1, "pin disabled");
		chk("pin released", {31'h0, pin_oe}, 32'h0);
		reg_rd(ADDR_PIN_CFG, 32'h0000_1010, "global kept");
		reg_rd(ADDR_SRC_STS, 32'h0400_0000, "status kept");
		reg_wr(ADDR_PIN_CFG, 32'hff00_0101);
		wait_line(1'b0, "asserted again");
		mir <= 5'h00;
		wait_line(1'b1, "released");
		reg_rd(ADDR_PIN_CFG, 32'hff00_2101, "hold-off active");
		pwr_ev <= 1'b1;
		@(posedge clk_i);
		pwr_ev <= 1'b0;
		wait_line(1'b0, "power bypass");
		reg_wr(ADDR_SRC_STS, 32'h0002_0000);
		wait_line(1'b1, "power cleared");
		// A new source inside the interval must stay off the pin
		mir <= 5'h02;
		repeat (8) @(posedge clk_i);
		chk("held off", {31'h0, line}, 32'h1);
		reg_wr(ADDR_PIN_CFG, 32'h0000_0101);
		wait_line(1'b0, "pending issued");
		reg_rd(ADDR_PIN_CFG, 32'h0000_1101, "hold-off cancel");
		mir <= 5'h00;
		wait_line(1'b1, "source gone");
		reg_wr(ADDR_SRC_EN, 32'h0);
		$display("test pin done");
	endtask
	task automatic t_soft();
		reg_wr(ADDR_PIN_CFG, 32'h0000_0111);
		soft_reset_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		soft_reset_i <= 1'b0;
		@(posedge clk_i);
		reg_rd(ADDR_PIN_CFG, 32'h0000_0010, "polarity kept");
		// Push-pull chosen before the debug clock so both levels are driven
		reg_wr(ADDR_PIN_CFG, 32'h0000_0101);
		// Polarity set here so the full reset below has something to restore
		reg_wr(ADDR_PIN_CFG, 32'h0000_0113);
		wait_line(1'b0, "clock low");
		xtal <= 1'b1;
		wait_line(1'b1, "clock high");
		reset_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		reset_i <= 1'b0;
		@(posedge clk_i);
		reg_rd(ADDR_PIN_CFG, 32'h0, "full reset");
		reg_rd(ADDR_SRC_STS, 32'h4000_0000, "ready after reset");
		$display("test soft done");
	endtask

	// =====================================================================
	// Clock and main sequence
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	initial begin
		reset_i = 1'b1;
		{soft_reset_i, psel, penable, pwrite, dev_rdy, gpt, pwr_ev, pwr_pend, xtal} = '0;
		paddr = 12'h000;
		pwdata = 32'h0;
		mir = 5'h00;
		strb = 4'hf;
		fails = 0;
		n_checks = 0;
		repeat (16) @(posedge clk_i);
		reset_i <= 1'b0;
		@(posedge clk_i);
		t_reset();
		t_mirror();
		t_w1c();
		t_pin();
		t_soft();
		tally_and_finish();
	end
endmodule
`default_nettype wire
